// ---- design/sfq_top.v ----
// instruction sequencer for multi-lane reads, burst wrap and page program
// assumes SCK, CS_N and lanes are synchronous to CLK and SCK runs at most CLK/4
`timescale 1ns/1ps
`include "sfq_defs.vh"
module sfq_top #(
  parameter PROG_CYCLES = `SFQ_TPP_CYC
) (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // serial link from the host
  input wire SCK,
  input wire CS_N,
  input wire [3:0] LANE_I,
  output reg [3:0] LANE_O,
  output reg [3:0] LANE_OE_N,
  // configuration and status
  input wire QUAD_LANE_ENABLE,
  input wire SW_RESET,
  input wire PAGE_LOCKED,
  output wire [15:0] PROT_PAGE,
  output wire BUSY,
  output reg WRITE_LATCH_FLAG,
  output reg WRAP_DISABLE_BIT,
  output reg [1:0] WRAP_LENGTH_FIELD,
  // array read port
  output wire [23:0] MEM_RD_ADDR,
  input wire [7:0] MEM_RD_DATA,
  // array write port
  output wire MEM_WR_VALID,
  input wire MEM_WR_READY,
  output wire [23:0] MEM_WR_ADDR,
  output wire [7:0] MEM_WR_DATA
);
  localparam ST_CMD = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_MODE = 3'h2;
  localparam ST_DUMMY = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_WRAP = 3'h5;
  localparam ST_PROG = 3'h6;
  localparam ST_HOLD = 3'h7;
  // ST_HOLD doubles as the dead state: extra clocks or refused opcodes land here

  reg sck_d_r;
  reg cs_d_r;
  reg [2:0] st_r;
  reg [5:0] cnt_r;
  reg [23:0] sh_r;
  reg [7:0] op_r;
  reg [2:0] iw_r;
  reg [2:0] ow_r;
  reg [5:0] mode_clks_r;
  reg [5:0] dummy_clks_r;
  reg [23:0] addr_r;
  reg [7:0] out_sh_r;
  reg [2:0] out_cnt_r;
  reg status_src_r;
  reg [15:0] pp_page_r;
  reg [7:0] pp_idx_r;
  reg got_byte_r;
  reg [7:0] page_buf_r [0:255];
  reg [255:0] mask_r;
  reg drain_act_r;
  reg [7:0] didx_r;

  wire sck_rise;
  wire sck_fall;
  wire cs_rise;
  wire [23:0] sh_in;
  wire [7:0] opc;
  wire [7:0] in_byte;
  wire [7:0] status_byte;
  wire [7:0] load_byte;
  wire wrap_on;
  wire prog_start;
  wire prog_done;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire drain_adv;

  assign sck_rise = SCK & ~sck_d_r & ~CS_N;
  assign sck_fall = ~SCK & sck_d_r & ~CS_N;
  assign cs_rise = CS_N & ~cs_d_r;
  assign sh_in = shift_in(sh_r, LANE_I, iw_r);
  assign opc = sh_in[7:0];
  assign in_byte = sh_in[7:0];
  assign status_byte = {6'h00, WRITE_LATCH_FLAG, BUSY};
  assign load_byte = status_src_r ? status_byte : MEM_RD_DATA;
  assign wrap_on = (op_r == `SFQ_OP_QUAD_IO) & ~WRAP_DISABLE_BIT;
  assign MEM_RD_ADDR = addr_r;
  assign PROT_PAGE = pp_page_r;
  // whole byte boundary and an unlocked page are the only way into a program cycle
  assign prog_start = cs_rise & (st_r == ST_PROG) & (cnt_r == `SFQ_BYTE_CLKS) &
                      got_byte_r & ~PAGE_LOCKED;

  // grouped sampling, highest lane is the most significant bit
  function [23:0] shift_in;
    input [23:0] sh;
    input [3:0] ln;
    input [2:0] w;
    begin
      case (w)
        3'h2: shift_in = {sh[21:0], ln[1:0]};
        3'h4: shift_in = {sh[19:0], ln[3:0]};
        default: shift_in = {sh[22:0], ln[0]};
      endcase
    end
  endfunction

  // lane values for the top group of an outgoing byte
  function [3:0] lane_drive;
    input [7:0] b;
    input [2:0] w;
    begin
      case (w)
        3'h2: lane_drive = {2'h0, b[7:6]};
        3'h4: lane_drive = b[7:4];
        default: lane_drive = {2'h0, b[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] lane_enable_n;
    input [2:0] w;
    begin
      case (w)
        3'h2: lane_enable_n = `SFQ_OE_X2;
        3'h4: lane_enable_n = `SFQ_OE_X4;
        default: lane_enable_n = `SFQ_OE_X1;
      endcase
    end
  endfunction

  function [7:0] shift_out;
    input [7:0] b;
    input [2:0] w;
    begin
      case (w)
        3'h2: shift_out = {b[5:0], 2'h0};
        3'h4: shift_out = {b[3:0], 4'h0};
        default: shift_out = {b[6:0], 1'b0};
      endcase
    end
  endfunction

  // next read address, wrapping inside the aligned section when asked
  function [23:0] next_addr;
    input [23:0] a;
    input wrap;
    input [1:0] len;
    reg [7:0] lm;
    reg [7:0] lo;
    begin
      lm = 8'h08 << len;
      lm = lm - 8'h01;
      lo = a[7:0] + 8'h01;
      if (wrap)
        next_addr = {a[23:8], (a[7:0] & ~lm) | (lo & lm)};
      else
        next_addr = a + 24'h000001;
    end
  endfunction

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      st_r <= ST_CMD;
      cnt_r <= `SFQ_CMD_CLKS;
      sh_r <= 24'h000000;
      op_r <= 8'h00;
      iw_r <= 3'h1;
      ow_r <= 3'h1;
      mode_clks_r <= 6'h00;
      dummy_clks_r <= 6'h00;
      addr_r <= 24'h000000;
      out_sh_r <= 8'h00;
      out_cnt_r <= 3'h0;
      status_src_r <= 1'b0;
      pp_page_r <= 16'h0000;
      pp_idx_r <= 8'h00;
      got_byte_r <= 1'b0;
      LANE_O <= 4'h0;
      LANE_OE_N <= `SFQ_OE_OFF;
      WRITE_LATCH_FLAG <= 1'b0;
      WRAP_DISABLE_BIT <= `SFQ_WRAP_DIS_RST;
      WRAP_LENGTH_FIELD <= `SFQ_WRAP_LEN_RST;
    end else begin
      sck_d_r <= SCK;
      cs_d_r <= CS_N;
      if (SW_RESET) begin
        WRAP_DISABLE_BIT <= `SFQ_WRAP_DIS_RST;
        WRAP_LENGTH_FIELD <= `SFQ_WRAP_LEN_RST;
      end
      if (prog_done || SW_RESET)
        WRITE_LATCH_FLAG <= 1'b0;
      if (cs_rise && st_r == ST_HOLD && cnt_r == `SFQ_CMD_CLKS) begin
        if (op_r == `SFQ_OP_WR_ENABLE)
          WRITE_LATCH_FLAG <= 1'b1;
        else if (op_r == `SFQ_OP_WR_DISABLE)
          WRITE_LATCH_FLAG <= 1'b0;
      end
      if (CS_N) begin
        st_r <= ST_CMD;
        cnt_r <= `SFQ_CMD_CLKS;
        iw_r <= 3'h1;
        out_cnt_r <= 3'h0;
        LANE_OE_N <= `SFQ_OE_OFF;
      end else if (sck_rise) begin
        sh_r <= sh_in;
        cnt_r <= cnt_r - 6'h01;
        case (st_r)
          ST_CMD: begin
            if (cnt_r == 6'h01) begin
              op_r <= opc;
              cnt_r <= `SFQ_ADDR_CLKS_X1;
              mode_clks_r <= 6'h00;
              dummy_clks_r <= `SFQ_DUMMY_OUT;
              status_src_r <= 1'b0;
              st_r <= ST_ADDR;
              if (BUSY && opc != `SFQ_OP_RD_STATUS) begin
                st_r <= ST_HOLD;
                op_r <= 8'h00;
              end else begin
                case (opc)
                  `SFQ_OP_DUAL_OUT: ow_r <= 3'h2;
                  `SFQ_OP_QUAD_OUT: begin
                    ow_r <= 3'h4;
                    if (!QUAD_LANE_ENABLE)
                      st_r <= ST_HOLD;
                  end
                  `SFQ_OP_DUAL_IO: begin
                    iw_r <= 3'h2;
                    ow_r <= 3'h2;
                    cnt_r <= `SFQ_ADDR_CLKS_X2;
                    mode_clks_r <= `SFQ_MODE_CLKS_X2;
                    dummy_clks_r <= 6'h00;
                  end
                  `SFQ_OP_QUAD_IO: begin
                    iw_r <= 3'h4;
                    ow_r <= 3'h4;
                    cnt_r <= `SFQ_ADDR_CLKS_X4;
                    mode_clks_r <= `SFQ_MODE_CLKS_X4;
                    dummy_clks_r <= `SFQ_DUMMY_QIO;
                    if (!QUAD_LANE_ENABLE)
                      st_r <= ST_HOLD;
                  end
                  `SFQ_OP_SET_WRAP: begin
                    iw_r <= 3'h4;
                    cnt_r <= `SFQ_ADDR_CLKS_X4;
                  end
                  `SFQ_OP_PAGE_PROG: begin
                    if (!WRITE_LATCH_FLAG)
                      st_r <= ST_HOLD;
                  end
                  `SFQ_OP_RD_STATUS: begin
                    ow_r <= 3'h1;
                    status_src_r <= 1'b1;
                    st_r <= ST_DATA;
                  end
                  `SFQ_OP_WR_ENABLE, `SFQ_OP_WR_DISABLE: begin
                    cnt_r <= `SFQ_CMD_CLKS;
                    st_r <= ST_HOLD;
                  end
                  default: st_r <= ST_HOLD;
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (cnt_r == 6'h01) begin
              addr_r <= sh_in;
              if (op_r == `SFQ_OP_SET_WRAP) begin
                cnt_r <= `SFQ_WRAP_CLKS;
                st_r <= ST_WRAP;
              end else if (op_r == `SFQ_OP_PAGE_PROG) begin
                pp_page_r <= sh_in[23:8];
                pp_idx_r <= sh_in[7:0];
                got_byte_r <= 1'b0;
                iw_r <= 3'h1;
                cnt_r <= `SFQ_BYTE_CLKS;
                st_r <= ST_PROG;
              end else if (mode_clks_r != 6'h00) begin
                cnt_r <= mode_clks_r;
                st_r <= ST_MODE;
              end else if (dummy_clks_r != 6'h00) begin
                cnt_r <= dummy_clks_r;
                st_r <= ST_DUMMY;
              end else
                st_r <= ST_DATA;
            end
          end
          ST_MODE: begin
            // mode bits are taken but continuous mode is not offered
            if (cnt_r == 6'h01) begin
              cnt_r <= dummy_clks_r;
              st_r <= (dummy_clks_r != 6'h00) ? ST_DUMMY : ST_DATA;
            end
          end
          ST_DUMMY: begin
            if (cnt_r == 6'h01)
              st_r <= ST_DATA;
          end
          ST_WRAP: begin
            if (cnt_r == 6'h01) begin
              WRAP_DISABLE_BIT <= in_byte[`SFQ_WRAP_DIS_POS];
              WRAP_LENGTH_FIELD <= in_byte[`SFQ_WRAP_LEN_LSB+1:`SFQ_WRAP_LEN_LSB];
              cnt_r <= `SFQ_CMD_CLKS;
              st_r <= ST_HOLD;
            end
          end
          ST_PROG: begin
            if (cnt_r == 6'h01) begin
              pp_idx_r <= pp_idx_r + 8'h01;
              got_byte_r <= 1'b1;
              cnt_r <= `SFQ_BYTE_CLKS;
            end
          end
          ST_DATA: cnt_r <= cnt_r;
          default: begin
            st_r <= ST_HOLD;
            cnt_r <= 6'h00;
          end
        endcase
      end else if (sck_fall && st_r == ST_DATA) begin
        // first falling edge after the last input clock drives the first group
        LANE_OE_N <= lane_enable_n(ow_r);
        if (out_cnt_r == 3'h0) begin
          LANE_O <= lane_drive(load_byte, ow_r);
          out_sh_r <= shift_out(load_byte, ow_r);
          out_cnt_r <= 3'h7 >> (ow_r >> 1);
          if (!status_src_r)
            addr_r <= next_addr(addr_r, wrap_on, WRAP_LENGTH_FIELD);
        end else begin
          LANE_O <= lane_drive(out_sh_r, ow_r);
          out_sh_r <= shift_out(out_sh_r, ow_r);
          out_cnt_r <= out_cnt_r - 3'h1;
        end
      end
    end
  end

  // page buffer write, index wraps inside the page
  always @(posedge CLK) begin
    if (sck_rise && st_r == ST_PROG && cnt_r == 6'h01)
      page_buf_r[pp_idx_r] <= in_byte;
  end

  assign fifo_in_valid = drain_act_r & mask_r[didx_r];
  assign drain_adv = drain_act_r & (~mask_r[didx_r] | fifo_in_ready);

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_r <= 256'h0;
      drain_act_r <= 1'b0;
      didx_r <= 8'h00;
    end else begin
      if (sck_rise && st_r == ST_ADDR && cnt_r == 6'h01 && op_r == `SFQ_OP_PAGE_PROG)
        mask_r <= 256'h0;
      else if (sck_rise && st_r == ST_PROG && cnt_r == 6'h01)
        mask_r[pp_idx_r] <= 1'b1;
      if (prog_start) begin
        drain_act_r <= 1'b1;
        didx_r <= 8'h00;
      end else if (drain_adv) begin
        didx_r <= didx_r + 8'h01;
        if (didx_r == 8'hFF)
          drain_act_r <= 1'b0;
      end
    end
  end

  sfq_fifo2 #(
    .W(32),
    .DEPTH(2),
    .AW(1)
  ) u_wbuf (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({pp_page_r, didx_r, page_buf_r[didx_r]}),
    .out_valid(MEM_WR_VALID),
    .out_ready(MEM_WR_READY),
    .out_data({MEM_WR_ADDR, MEM_WR_DATA})
  );

  sfq_prog #(
    .PROG_CYCLES(PROG_CYCLES),
    .CW(24)
  ) u_prog (
    .clk(CLK),
    .rst_n(RST_N),
    .start(prog_start),
    .drain_busy(drain_act_r | MEM_WR_VALID),
    .busy(BUSY),
    .done(prog_done)
  );
endmodule

// ---- design/sfq_defs.vh ----
// constants for the multi-lane read and page program sequencer
// assumes CLK at 50 MHz and the serial clock sampled as an ordinary input
// Notes on behaviour
// - Dual-output read: opcode and address on one lane, data two bits per clock.
// - Dual and quad output reads: eight dummy clocks after address, lanes ignored.
// - Quad-output read accepted only with quad lane enable set; four bits per clock.
// - Dual I/O read: address two bits per clock on lanes zero and one.
// - Quad I/O read: address on four lanes, four dummy clocks, data on four.
// - Quad I/O read runs only with quad lane enable set.
// - Wrap on: quad I/O read wraps inside the aligned section until select rises.
// - Wrap setting: opcode, 24 dummy bits, eight wrap bits; W7 and low nibble ignored.
// - Wrap disable 0 wraps over 8/16/32/64 bytes per length code; 1 never wraps.
// - Stored wrap setting applies to all later quad I/O reads until rewritten.
// - Wrap disable bit is 1 after power-on, software reset or hardware reset.
// - Page program: select low, opcode, 24-bit address, data bytes on one lane.
// - Page program accepted only when the write latch flag is 1.
// - Program bytes wrap within the 256-byte page and overwrite earlier bytes.
// - Select must rise right after a whole byte, else no program happens.
// - Valid program starts a timed cycle; busy is 1 throughout, 0 at the end.
// - Status reads are still answered while a program cycle runs.
// - Write latch flag clears when the program cycle completes.
// - A protected page is never programmed.
// - Inputs latched on rising edges, data driven on falling edges, MSB first, auto-increment.
// - Write enable sets the write latch flag and must precede page program.
`ifndef SFQ_DEFS_VH
`define SFQ_DEFS_VH

`define SFQ_OP_DUAL_OUT 8'h3B
`define SFQ_OP_QUAD_OUT 8'h6B
`define SFQ_OP_DUAL_IO 8'hBB
`define SFQ_OP_QUAD_IO 8'hEB
`define SFQ_OP_SET_WRAP 8'h77
`define SFQ_OP_PAGE_PROG 8'h02
`define SFQ_OP_WR_ENABLE 8'h06
`define SFQ_OP_WR_DISABLE 8'h04
`define SFQ_OP_RD_STATUS 8'h05

`define SFQ_CMD_CLKS 6'h08
`define SFQ_ADDR_CLKS_X1 6'h18
`define SFQ_ADDR_CLKS_X2 6'h0C
`define SFQ_ADDR_CLKS_X4 6'h06
`define SFQ_MODE_CLKS_X2 6'h04
`define SFQ_MODE_CLKS_X4 6'h02
`define SFQ_DUMMY_OUT 6'h08
`define SFQ_DUMMY_QIO 6'h04
`define SFQ_WRAP_CLKS 6'h02
`define SFQ_BYTE_CLKS 6'h08

`define SFQ_WRAP_DIS_POS 4
`define SFQ_WRAP_LEN_LSB 5
`define SFQ_WRAP_DIS_RST 1'b1
`define SFQ_WRAP_LEN_RST 2'h0

`define SFQ_OE_X1 4'hD
`define SFQ_OE_X2 4'hC
`define SFQ_OE_X4 4'h0
`define SFQ_OE_OFF 4'hF

`define SFQ_CLK_NS 20
`define SFQ_TPP_NS 400000
`define SFQ_TPP_CYC ((`SFQ_TPP_NS + `SFQ_CLK_NS - 1) / `SFQ_CLK_NS)

`endif

// ---- design/sfq_fifo2.v ----
// small valid/ready buffer between the program drain and the array write port
// assumes one clock; depth and width set the storage
`timescale 1ns/1ps
module sfq_fifo2 #(
  parameter W = 32,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] count_r;
  wire push;
  wire pop;

  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1)
        bump = {AW{1'b0}};
      else
        bump = p + 1'b1;
    end
  endfunction

  always @(posedge clk) begin
    if (push)
      mem_r[wptr_r] <= in_data;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wptr_r <= bump(wptr_r);
      if (pop)
        rptr_r <= bump(rptr_r);
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// ---- design/sfq_prog.v ----
// self-timed program cycle: busy from start until time is up and the page is drained
// assumes start is a one-cycle pulse that never comes while busy
`timescale 1ns/1ps
module sfq_prog #(
  parameter PROG_CYCLES = 20000,
  parameter CW = 24
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire start,
  input wire drain_busy,
  // status
  output reg busy,
  output reg done
);
  reg [CW-1:0] cnt_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {CW{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt_r <= PROG_CYCLES[CW-1:0] - 1'b1;
      end else if (busy) begin
        if (cnt_r != {CW{1'b0}})
          cnt_r <= cnt_r - 1'b1;
        else if (!drain_busy) begin
          // array writes may stall; the cycle never ends with bytes still queued
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- bench/sfq_top_sva.sv ----
// port checker for the lane sequencer top
// assumes a bind onto sfq_top, one clock, async active-low reset
`timescale 1ns/1ps
module sfq_top_sva #(
  parameter PROG_CYCLES = 40
) (
  // clock and reset
  input wire CLK,
  input wire RST_N,
  // serial link
  input wire SCK,
  input wire CS_N,
  input wire [3:0] LANE_O,
  input wire [3:0] LANE_OE_N,
  // status and config
  input wire QUAD_LANE_ENABLE,
  input wire SW_RESET,
  input wire PAGE_LOCKED,
  input wire [15:0] PROT_PAGE,
  input wire BUSY,
  input wire WRITE_LATCH_FLAG,
  input wire WRAP_DISABLE_BIT,
  input wire [1:0] WRAP_LENGTH_FIELD,
  // array write port
  input wire MEM_WR_VALID,
  input wire MEM_WR_READY,
  input wire [23:0] MEM_WR_ADDR,
  input wire [7:0] MEM_WR_DATA
);
  reg [31:0] busy_cnt_r;
  // length of the current busy stretch, still held on the edge where busy falls
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      busy_cnt_r <= 32'h0;
    else if (BUSY)
      busy_cnt_r <= busy_cnt_r + 32'h1;
    else
      busy_cnt_r <= 32'h0;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  busy_len_a: assert property ($fell(BUSY) |-> busy_cnt_r >= PROG_CYCLES)
    else $error("busy ended before program time");
  wel_clear_a: assert property ($fell(BUSY) |=> !WRITE_LATCH_FLAG)
    else $error("write latch still set after program");
  busy_start_a: assert property ($rose(BUSY) |-> $past(CS_N) && WRITE_LATCH_FLAG && !$past(PAGE_LOCKED))
    else $error("program started without select rise, latch or unlocked page");
  idle_release_a: assert property (CS_N && $past(CS_N) |-> LANE_OE_N == 4'hF)
    else $error("lanes driven while deselected");
  quad_gate_a: assert property (LANE_OE_N == 4'h0 |-> QUAD_LANE_ENABLE)
    else $error("four lanes driven without quad enable");
  fall_drive_a: assert property ($changed(LANE_O) && !$past(CS_N) |-> !$past(SCK))
    else $error("lane output changed away from a falling clock");
  wr_hold_a: assert property (MEM_WR_VALID && !MEM_WR_READY |=> MEM_WR_VALID && $stable(MEM_WR_ADDR) && $stable(MEM_WR_DATA))
    else $error("write word lost during stall");
  wr_page_a: assert property (MEM_WR_VALID |-> MEM_WR_ADDR[23:8] == PROT_PAGE && BUSY)
    else $error("write outside program page or cycle");
  wrap_reset_a: assert property (SW_RESET |=> WRAP_DISABLE_BIT && WRAP_LENGTH_FIELD == 2'h0)
    else $error("wrap setting not reset");
endmodule

// ---- bench/sfq_host.sv ----
// host side model: serial clock, select and the four shared lanes
// assumes the bench calls its tasks from a clock edge; idle clock low
`timescale 1ns/1ps
module sfq_host (
  // clock
  input wire clk,
  // link
  output reg sck,
  output reg cs_n,
  output wire [3:0] lane_i,
  input wire [3:0] lane_o,
  input wire [3:0] lane_oe_n
);
  reg [3:0] hoe;
  reg [3:0] hv;
  // a lane nobody drives shows the inverse of the last host value
  assign lane_i = (hoe & hv) | (~hoe & ~lane_oe_n & lane_o) | (~hoe & lane_oe_n & ~hv);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hoe = 4'h0;
    hv = 4'h0;
  end
  task sel;
    begin
      @(posedge clk);
      #1 cs_n = 1'b0;
    end
  endtask
  task desel;
    begin
      @(posedge clk);
      #1 sck = 1'b0;
      repeat (2) @(posedge clk);
      #1 cs_n = 1'b1;
      hoe = 4'h0;
      repeat (4) @(posedge clk);
    end
  endtask
  // n clocks of w lanes, MSB group first; lane 1 is the single-lane output
  task io(input integer w, input integer n, input drv, input [31:0] v, output [31:0] r);
    integer k;
    reg [3:0] m;
    begin
      m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
      r = 32'h0;
      @(posedge clk);
      #1 hoe = drv ? m : 4'h0;
      for (k = n - 1; k >= 0; k = k - 1) begin
        @(posedge clk);
        #1 sck = 1'b0;
        hv = m & 4'(v >> (w * k));
        repeat (3) @(posedge clk);
        #1 sck = 1'b1;
        r = (r << w) | {28'h0, (w == 1) ? {3'h0, lane_i[1]} : (lane_i & m)};
        repeat (3) @(posedge clk);
      end
    end
  endtask
endmodule

// ---- bench/tb_sfq_top.sv ----
// self-checking bench for the lane sequencer: reads, wrap, page program
// assumes sfq_top, the host model and an array modelled here
`timescale 1ns/1ps
module tb_sfq_top;
  localparam PROG_CYCLES = 400;
  reg CLK = 1'b0;
  reg RST_N = 1'b0;
  reg QUAD_LANE_ENABLE = 1'b0, SW_RESET = 1'b0, PAGE_LOCKED = 1'b0, MEM_WR_READY = 1'b0;
  wire SCK, CS_N, BUSY, WRITE_LATCH_FLAG, WRAP_DISABLE_BIT, MEM_WR_VALID;
  wire [3:0] LANE_I, LANE_O, LANE_OE_N;
  wire [15:0] PROT_PAGE;
  wire [1:0] WRAP_LENGTH_FIELD;
  wire [23:0] MEM_RD_ADDR, MEM_WR_ADDR;
  wire [7:0] MEM_WR_DATA;
  wire [7:0] MEM_RD_DATA = MEM_RD_ADDR[7:0] ^ 8'h3C;
  reg [7:0] wr_mem [0:255];
  reg [33:0] rows [0:5];
  reg [31:0] r;
  reg [23:0] a;
  reg drove;
  integer fails = 0, n_tests = 0, wr_n = 0, cyc = 0, i, k;
  always #10 CLK = ~CLK;
  sfq_top #(.PROG_CYCLES(PROG_CYCLES)) sfq_top_i (.CLK(CLK), .RST_N(RST_N), .SCK(SCK),
    .CS_N(CS_N), .LANE_I(LANE_I), .LANE_O(LANE_O), .LANE_OE_N(LANE_OE_N),
    .QUAD_LANE_ENABLE(QUAD_LANE_ENABLE), .SW_RESET(SW_RESET), .PAGE_LOCKED(PAGE_LOCKED),
    .PROT_PAGE(PROT_PAGE), .BUSY(BUSY), .WRITE_LATCH_FLAG(WRITE_LATCH_FLAG),
    .WRAP_DISABLE_BIT(WRAP_DISABLE_BIT), .WRAP_LENGTH_FIELD(WRAP_LENGTH_FIELD),
    .MEM_RD_ADDR(MEM_RD_ADDR), .MEM_RD_DATA(MEM_RD_DATA), .MEM_WR_VALID(MEM_WR_VALID),
    .MEM_WR_READY(MEM_WR_READY), .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WR_DATA(MEM_WR_DATA));
  sfq_host sfq_host_i (.clk(CLK), .sck(SCK), .cs_n(CS_N), .lane_i(LANE_I), .lane_o(LANE_O),
    .lane_oe_n(LANE_OE_N));
  // array write side stalls 8 cycles of 16 so the two-entry buffer backs up
  always @(posedge CLK) begin
    if (MEM_WR_VALID === 1'b1 && MEM_WR_READY) begin
      wr_mem[MEM_WR_ADDR[7:0]] = MEM_WR_DATA;
      wr_n = wr_n + 1;
    end
    if (LANE_OE_N !== 4'hF)
      drove = 1'b1;
    cyc = cyc + 1;
    #1 MEM_WR_READY = cyc[3];
  end
  task end_of_test;
    begin
      if (fails == 0 && n_tests > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch %0s exp %0h got %0h", name, exp, got);
      end
    end
  endtask
  function [31:0] expd(input [23:0] ad, input integer nb, input wrp, input [1:0] len);
    integer j;
    reg [7:0] p, s;
    begin
      expd = 32'h0;
      p = ad[7:0];
      s = 8'h08 << len;
      for (j = 0; j < nb; j = j + 1) begin
        expd = {expd[23:0], p ^ 8'h3C};
        p = wrp ? ((p & ~(s - 8'h01)) | ((p + 8'h01) & (s - 8'h01))) : p + 8'h01;
      end
    end
  endfunction
  task cmd(input [7:0] op, input integer n, input [31:0] v, output [31:0] q);
    reg [31:0] x;
    begin
      sfq_host_i.sel;
      sfq_host_i.io(1, 8, 1'b1, {24'h0, op}, x);
      if (op == 8'h02)
        sfq_host_i.io(1, 24, 1'b1, {8'h0, a}, x);
      if (n > 0)
        sfq_host_i.io(1, n, op != 8'h05, v, q);
      sfq_host_i.desel;
    end
  endtask
  task rd(input [7:0] op, input [23:0] ad, input integer nb, output [31:0] q);
    reg [31:0] x;
    integer aw, dw, dm;
    begin
      aw = (op == 8'hBB) ? 2 : (op == 8'hEB) ? 4 : 1;
      dw = (op == 8'h3B || op == 8'hBB) ? 2 : 4;
      dm = (op == 8'hEB) ? 4 : (op == 8'hBB) ? 0 : 8;
      sfq_host_i.sel;
      sfq_host_i.io(1, 8, 1'b1, {24'h0, op}, x);
      sfq_host_i.io(aw, 24 / aw, 1'b1, {8'h0, ad}, x);
      if (aw > 1)
        sfq_host_i.io(aw, 8 / aw, 1'b1, 32'hF0, x);
      if (dm > 0)
        sfq_host_i.io(aw, dm, 1'b1, 32'hA5A5, x);
      sfq_host_i.io(dw, nb * 8 / dw, 1'b0, 32'h0, q);
      sfq_host_i.desel;
    end
  endtask
  task wb(input [7:0] w);
    reg [31:0] x;
    begin
      sfq_host_i.sel;
      sfq_host_i.io(1, 8, 1'b1, 32'h77, x);
      sfq_host_i.io(4, 6, 1'b1, 32'h0, x);
      sfq_host_i.io(4, 2, 1'b1, {24'h0, w}, x);
      sfq_host_i.desel;
    end
  endtask
  initial begin
    // op, quad enable, drives, address
    rows[0] = {8'h3B, 1'b0, 1'b1, 24'h000010};
    rows[1] = {8'h6B, 1'b1, 1'b1, 24'h0000F3};
    rows[2] = {8'h6B, 1'b0, 1'b0, 24'h000020};
    rows[3] = {8'hBB, 1'b0, 1'b1, 24'h123456};
    rows[4] = {8'hEB, 1'b1, 1'b1, 24'h0000FE};
    rows[5] = {8'hEB, 1'b0, 1'b0, 24'h000030};
    repeat (6) @(posedge CLK);
    #1 RST_N = 1'b1;
    repeat (2) @(posedge CLK);
    chk("wrapdis", 1, WRAP_DISABLE_BIT);
    chk("wrent", 0, WRITE_LATCH_FLAG);
    for (i = 0; i < 6; i = i + 1) begin
      #1 QUAD_LANE_ENABLE = rows[i][25];
      drove = 1'b0;
      rd(rows[i][33:26], rows[i][23:0], 2, r);
      chk("drove", rows[i][24], drove);
      if (rows[i][24])
        chk("rdata", expd(rows[i][23:0], 2, 0, 0), r);
    end
    #1 QUAD_LANE_ENABLE = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      wb(8'h85 | (i << 5));
      chk("wraplen", i, WRAP_LENGTH_FIELD);
      chk("wrapdis", 0, WRAP_DISABLE_BIT);
      a = 24'h000340 + (8 << i) - 2;
      rd(8'hEB, a, 4, r);
      chk("wrapdata", expd(a, 4, 1, i), r);
    end
    wb(8'h10);
    rd(8'hEB, 24'h000346, 4, r);
    chk("linear", expd(24'h000346, 4, 0, 0), r);
    wb(8'h65);
    #1 SW_RESET = 1'b1;
    repeat (2) @(posedge CLK);
    #1 SW_RESET = 1'b0;
    @(posedge CLK);
    chk("swreset", 3'h4, {WRAP_DISABLE_BIT, WRAP_LENGTH_FIELD});
    wb(8'h65);
    #1 RST_N = 1'b0;
    @(posedge CLK);
    #1 RST_N = 1'b1;
    repeat (2) @(posedge CLK);
    chk("hwreset", 3'h4, {WRAP_DISABLE_BIT, WRAP_LENGTH_FIELD});
    a = 24'h000100;
    cmd(8'h02, 8, 32'h55, r);
    chk("busy", 0, BUSY);
    cmd(8'h06, 0, 32'h0, r);
    chk("wrent", 1, WRITE_LATCH_FLAG);
    cmd(8'h02, 12, 32'h555, r);
    chk("busy", 0, BUSY);
    chk("wrent", 1, WRITE_LATCH_FLAG);
    #1 PAGE_LOCKED = 1'b1;
    cmd(8'h02, 8, 32'h55, r);
    chk("busy", 0, BUSY);
    #1 PAGE_LOCKED = 1'b0;
    a = 24'h0012FE;
    cmd(8'h02, 24, 32'hA1B2C3, r);
    chk("busy", 1, BUSY);
    chk("page", 16'h0012, PROT_PAGE);
    cmd(8'h05, 8, 32'h0, r);
    chk("status", 8'h03, r);
    for (k = 0; k < 2000 && BUSY !== 1'b0; k = k + 1)
      @(posedge CLK);
    #1 chk("busy", 0, BUSY);
    chk("wrent", 0, WRITE_LATCH_FLAG);
    chk("wrcount", 3, wr_n);
    chk("wrdata", 24'hC3A1B2, {wr_mem[0], wr_mem[254], wr_mem[255]});
    cmd(8'h06, 0, 32'h0, r);
    cmd(8'h04, 0, 32'h0, r);
    chk("wrent", 0, WRITE_LATCH_FLAG);
    end_of_test;
  end
  initial begin
    #400000;
    fails = fails + 1;
    end_of_test;
  end
endmodule
bind sfq_top sfq_top_sva #(.PROG_CYCLES(PROG_CYCLES)) sfq_top_sva_i (.CLK(CLK), .RST_N(RST_N),
  .SCK(SCK), .CS_N(CS_N), .LANE_O(LANE_O), .LANE_OE_N(LANE_OE_N),
  .QUAD_LANE_ENABLE(QUAD_LANE_ENABLE), .SW_RESET(SW_RESET), .PAGE_LOCKED(PAGE_LOCKED),
  .PROT_PAGE(PROT_PAGE), .BUSY(BUSY), .WRITE_LATCH_FLAG(WRITE_LATCH_FLAG),
  .WRAP_DISABLE_BIT(WRAP_DISABLE_BIT), .WRAP_LENGTH_FIELD(WRAP_LENGTH_FIELD),
  .MEM_WR_VALID(MEM_WR_VALID), .MEM_WR_READY(MEM_WR_READY), .MEM_WR_ADDR(MEM_WR_ADDR),
  .MEM_WR_DATA(MEM_WR_DATA));
